// ---- core/lcdiv_channel.sv ----
// Purpose: two cascaded programmable dividers of channel 3 plus channel 4 first stage
// Assumes: divIn is an asynchronous divider input clock from a pin, synchronised and sampled as data
// Notes:
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`include "lcdiv_params.svh"
module lcdiv_channel (
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	// apb slave
	input  wire lcdiv_pkg::lcdiv_apb_req_t apbReq,
	output logic        [31:0]          prdata,
	output logic                        pready,
	output logic                        pslverr,
	// divider input and chip sync, from pins
	input  wire logic                   divIn,
	input  wire logic                   syncIn_n,
	// divider outputs
	output logic                        chan3Out,
	output logic                        chan4Stage1Out,
	output logic                        dutyCorrEn
);
	import lcdiv_pkg::*;

	logic [7:0] c3s1_r, c3ph_r, c3s2_r, c3ctl_r, c3dcc_r, c4s1_r;
	logic [1:0] inSync_r, syncSync_r;
	logic       inPrev_r;

	// register decode
	wire [9:0] regIdx   = apbReq.paddr[11:2];
	wire       setup    = apbReq.psel && !apbReq.penable;
	wire       access   = apbReq.psel && apbReq.penable;
	wire       hitS1    = regIdx == `LCDIV_IDX_C3S1;
	wire       hitPh    = regIdx == `LCDIV_IDX_C3PH;
	wire       hitS2    = regIdx == `LCDIV_IDX_C3S2;
	wire       hitCtl   = regIdx == `LCDIV_IDX_C3CTL;
	wire       hitDcc   = regIdx == `LCDIV_IDX_C3DCC;
	wire       hitC4    = regIdx == `LCDIV_IDX_C4S1;
	wire       mapped   = hitS1 | hitPh | hitS2 | hitCtl | hitDcc | hitC4;
	wire       wrEn     = access && apbReq.pwrite && mapped;
	wire [7:0] wrByte   = apbReq.pwdata[7:0];
	wire [7:0] rdByte   = hitS1 ? c3s1_r : hitPh ? c3ph_r : hitS2 ? c3s2_r :
	                      hitCtl ? c3ctl_r : hitDcc ? c3dcc_r : hitC4 ? c4s1_r : 8'h00;

	// apb: one wait-free access phase, answer registered at setup
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			prdata  <= (setup && !apbReq.pwrite) ? {24'h00_0000, rdByte} : 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			c3s1_r  <= `LCDIV_RST_CYCLES;
			c3ph_r  <= `LCDIV_RST_PHASE;
			c3s2_r  <= `LCDIV_RST_CYCLES;
			c3ctl_r <= `LCDIV_RST_CTL;
			c3dcc_r <= `LCDIV_RST_DCC;
			c4s1_r  <= `LCDIV_RST_CYCLES;
		end else if (wrEn && pready) begin
			if (hitS1) c3s1_r <= wrByte;
			if (hitPh) c3ph_r <= wrByte;
			if (hitS2) c3s2_r <= wrByte;
			if (hitCtl) c3ctl_r <= {2'b00, wrByte[5:0]};
			if (hitDcc) c3dcc_r <= {7'h00, wrByte[0]};
			if (hitC4) c4s1_r <= wrByte;
		end
	end

	// pin synchronisers; only stage two is read
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			inSync_r   <= 2'b00;
			syncSync_r <= 2'b11;
			inPrev_r   <= 1'b0;
		end else begin
			inSync_r   <= {inSync_r[0], divIn};
			syncSync_r <= {syncSync_r[0], syncIn_n};
			inPrev_r   <= inSync_r[1];
		end
	end

	wire inRise   = inSync_r[1] && !inPrev_r;
	wire noSync   = c3ctl_r[`LCDIV_BIT_NOSYNC];
	// sync held low restarts dividers; ignored when nosync set
	wire syncHold = !syncSync_r[1] && !noSync;

	// divider stage: counts input events, phase offset preloads the channel 3 counts, channel 4 count starts at zero
	logic [3:0] cnt1_r, cnt2_r, cnt4_r;
	logic       lvl1_r, lvl2_r, lvl4_r;

	function automatic logic [3:0] lim(input logic [7:0] cyc, input logic lvl);
		lim = lvl ? cyc[3:0] : cyc[7:4];
	endfunction : lim

	wire byp1   = c3ctl_r[`LCDIV_BIT_BYP1];
	wire byp2   = c3ctl_r[`LCDIV_BIT_BYP2];
	wire st1    = c3ctl_r[`LCDIV_BIT_START1];
	wire st2    = c3ctl_r[`LCDIV_BIT_START2];
	wire wrap1  = cnt1_r == lim(c3s1_r, lvl1_r);
	wire wrap2  = cnt2_r == lim(c3s2_r, lvl2_r);
	wire wrap4  = cnt4_r == lim(c4s1_r, lvl4_r);
	// first stage rising edge is one input cycle of the second stage
	wire s1Edge = byp1 ? inRise : (inRise && wrap1 && !lvl1_r);
	wire s1Lvl  = byp1 ? inSync_r[1] : lvl1_r;
	wire s2Lvl  = byp2 ? s1Lvl : lvl2_r;

	always_ff @(posedge core_clk) begin
		if (!rst_n || syncHold) begin
			cnt1_r <= c3ph_r[3:0];
			cnt2_r <= c3ph_r[7:4];
			cnt4_r <= 4'h0;
			lvl1_r <= st1;
			lvl2_r <= st2;
			lvl4_r <= 1'b0;
		end else begin
			if (!byp1 && inRise) begin
				cnt1_r <= wrap1 ? 4'h0 : cnt1_r + 4'h1;
				if (wrap1) lvl1_r <= !lvl1_r;
			end
			if (!byp2 && s1Edge) begin
				cnt2_r <= wrap2 ? 4'h0 : cnt2_r + 4'h1;
				if (wrap2) lvl2_r <= !lvl2_r;
			end
			if (inRise) begin
				cnt4_r <= wrap4 ? 4'h0 : cnt4_r + 4'h1;
				if (wrap4) lvl4_r <= !lvl4_r;
			end
		end
	end

	// output: forced level applies only with nosync set
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			chan3Out       <= 1'b0;
			chan4Stage1Out <= 1'b0;
			dutyCorrEn     <= 1'b1;
		end else begin
			chan3Out       <= noSync ? c3ctl_r[`LCDIV_BIT_FORCE] : s2Lvl;
			chan4Stage1Out <= lvl4_r;
			dutyCorrEn     <= !c3dcc_r[`LCDIV_BIT_DUTY_CORRECTION_DISABLE];
		end
	end

	// steps of the divider stages and the register write, shared by the checks below
	sequence seqS1Step;
		!byp1 && !syncHold && inRise;
	endsequence

	sequence seqS2Step;
		!byp2 && !syncHold && s1Edge;
	endsequence

	sequence seqC4Step;
		!syncHold && inRise;
	endsequence

	sequence seqWrite;
		wrEn && pready;
	endsequence

	AST_READY_ONE: assert property (@(posedge core_clk) disable iff (!rst_n)
		pready |=> !pready) else $error("pready held more than one cycle");
	AST_FORCE: assert property (@(posedge core_clk) disable iff (!rst_n)
		noSync |=> chan3Out == $past(c3ctl_r[`LCDIV_BIT_FORCE])) else $error("force ignored");
	AST_DCC: assert property (@(posedge core_clk) disable iff (!rst_n)
		c3dcc_r[0] |=> !dutyCorrEn) else $error("duty correction not disabled");
	AST_SYNC_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		syncHold |=> lvl1_r == $past(st1)) else $error("start level wrong");
	AST_SYNC2: assert property (@(posedge core_clk) disable iff (!rst_n)
		syncHold |=> lvl2_r == $past(st2)) else $error("stage two start wrong");
	AST_PHASE: assert property (@(posedge core_clk) disable iff (!rst_n)
		syncHold |=> cnt1_r == $past(c3ph_r[3:0])) else $error("phase not loaded");
	AST_BYP1: assert property (@(posedge core_clk) disable iff (!rst_n)
		byp1 && !syncHold |=> $stable(cnt1_r)) else $error("bypassed stage counts");
	AST_BYP2: assert property (@(posedge core_clk) disable iff (!rst_n)
		byp2 && !syncHold |=> $stable(cnt2_r)) else $error("bypassed stage two counts");
	AST_S1CNT: assert property (@(posedge core_clk) disable iff (!rst_n)
		!byp1 && !syncHold && inRise && !wrap1 |=> cnt1_r == $past(cnt1_r) + 4'h1)
		else $error("stage one count");
	AST_C4CNT: assert property (@(posedge core_clk) disable iff (!rst_n)
		!syncHold && inRise && wrap4 |=> lvl4_r != $past(lvl4_r)) else $error("c4 toggle");
	AST_S2CASC: assert property (@(posedge core_clk) disable iff (!rst_n)
		!byp2 && !syncHold && !s1Edge |=> $stable(cnt2_r))
		else $error("stage two stepped without stage one");

	AST_S1_LOW_END: assert property (@(posedge core_clk) disable iff (!rst_n)
		seqS1Step ##0 (wrap1 && !lvl1_r) |=> lvl1_r && cnt1_r == 4'h0)
		else $error("stage one low phase end");

	AST_S1_HIGH_END: assert property (@(posedge core_clk) disable iff (!rst_n)
		seqS1Step ##0 (wrap1 && lvl1_r) |=> !lvl1_r && cnt1_r == 4'h0)
		else $error("stage one high phase end");

	AST_S1_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
		!syncHold && !inRise |=> $stable(cnt1_r) && $stable(lvl1_r))
		else $error("stage one moved without input edge");

	AST_S2_STEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		seqS2Step ##0 !wrap2 |=> cnt2_r == $past(cnt2_r) + 4'h1)
		else $error("stage two count");

	AST_S2_END: assert property (@(posedge core_clk) disable iff (!rst_n)
		seqS2Step ##0 wrap2 |=> lvl2_r != $past(lvl2_r) && cnt2_r == 4'h0)
		else $error("stage two phase end");

	AST_C4_STEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		seqC4Step ##0 !wrap4 |=> cnt4_r == $past(cnt4_r) + 4'h1)
		else $error("c4 count");

	AST_C4_OUT: assert property (@(posedge core_clk) disable iff (!rst_n)
		1'b1 |=> chan4Stage1Out == $past(lvl4_r))
		else $error("c4 output level");

	AST_PHASE2: assert property (@(posedge core_clk) disable iff (!rst_n)
		syncHold |=> cnt2_r == $past(c3ph_r[7:4]))
		else $error("stage two phase not loaded");

	AST_SYNC_IGN: assert property (@(posedge core_clk) disable iff (!rst_n)
		noSync && !syncSync_r[1] && !byp1 && inRise && !wrap1 |=>
		cnt1_r == $past(cnt1_r) + 4'h1)
		else $error("sync obeyed while ignored");

	AST_OUT_BYP_BOTH: assert property (@(posedge core_clk) disable iff (!rst_n)
		!noSync && byp1 && byp2 |=> chan3Out == $past(inSync_r[1]))
		else $error("both stages bypassed but input not passed");

	AST_OUT_BYP2: assert property (@(posedge core_clk) disable iff (!rst_n)
		!noSync && !byp1 && byp2 |=> chan3Out == $past(lvl1_r))
		else $error("stage two bypass not passing stage one");

	AST_OUT_DIV: assert property (@(posedge core_clk) disable iff (!rst_n)
		!noSync && !byp2 |=> chan3Out == $past(lvl2_r))
		else $error("channel output not from stage two");

	AST_DCC_ON: assert property (@(posedge core_clk) disable iff (!rst_n)
		!c3dcc_r[0] |=> dutyCorrEn)
		else $error("duty correction not enabled");

	AST_WR_S1: assert property (@(posedge core_clk) disable iff (!rst_n)
		seqWrite ##0 hitS1 |=> c3s1_r == $past(wrByte))
		else $error("stage one cycles not written");

	AST_WR_S2: assert property (@(posedge core_clk) disable iff (!rst_n)
		seqWrite ##0 hitS2 |=> c3s2_r == $past(wrByte))
		else $error("stage two cycles not written");

	AST_WR_PH: assert property (@(posedge core_clk) disable iff (!rst_n)
		seqWrite ##0 hitPh |=> c3ph_r == $past(wrByte))
		else $error("phase offsets not written");

	AST_WR_C4: assert property (@(posedge core_clk) disable iff (!rst_n)
		seqWrite ##0 hitC4 |=> c4s1_r == $past(wrByte))
		else $error("c4 cycles not written");

	AST_WR_CTL: assert property (@(posedge core_clk) disable iff (!rst_n)
		seqWrite ##0 hitCtl |=> c3ctl_r == {2'b00, $past(wrByte[5:0])})
		else $error("control not written");

	AST_RD_CTL: assert property (@(posedge core_clk) disable iff (!rst_n)
		setup && !apbReq.pwrite && hitCtl |=> prdata == {24'h00_0000, $past(c3ctl_r)})
		else $error("control read data");

	AST_ERR_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n)
		pslverr |-> pready)
		else $error("error without ready");
endmodule : lcdiv_channel

// ---- core/lcdiv_params.svh ----
// Purpose: register offsets, field positions and reset values of the channel divider
// Assumes: APB byte addresses are four times the register index
// Notes: definitions only
`ifndef LCDIV_PARAMS_SVH
`define LCDIV_PARAMS_SVH
`define LCDIV_IDX_C3S1       10'h199
`define LCDIV_IDX_C3PH       10'h19a
`define LCDIV_IDX_C3S2       10'h19b
`define LCDIV_IDX_C3CTL      10'h19c
`define LCDIV_IDX_C3DCC      10'h19d
`define LCDIV_IDX_C4S1       10'h19e
`define LCDIV_RST_CYCLES     8'h00
`define LCDIV_RST_PHASE      8'h00
`define LCDIV_RST_CTL        8'h00
`define LCDIV_RST_DCC        8'h00
`define LCDIV_BIT_BYP2       5
`define LCDIV_BIT_BYP1       4
`define LCDIV_BIT_NOSYNC     3
`define LCDIV_BIT_FORCE      2
`define LCDIV_BIT_START2     1
`define LCDIV_BIT_START1     0
`define LCDIV_BIT_DUTY_CORRECTION_DISABLE     0
`endif

// ---- core/lcdiv_pkg.sv ----
// Purpose: shared types of the channel divider
// Assumes: nothing
// Notes: apb request travels as one struct
package lcdiv_pkg;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} lcdiv_apb_req_t;
	typedef struct packed {
		logic [3:0] low;
		logic [3:0] high;
	} lcdiv_cycles_t;
endpackage : lcdiv_pkg

// ---- tb/test_lcdiv_channel.sv ----
// Purpose: self-checking bench of the channel divider
// Assumes: divIn period is four core_clk cycles
// Notes: random register data from a fixed seed
`timescale 1ns/100ps
`include "lcdiv_params.svh"
module test_lcdiv_channel;
	import lcdiv_pkg::*;
	logic           core_clk = 1'b0;
	logic           rst_n = 1'b0;
	lcdiv_apb_req_t req = '0;
	logic [31:0]    prdata;
	logic           pready;
	logic           pslverr;
	logic           divIn = 1'b0;
	logic           syncIn_n = 1'b1;
	logic           chan3Out;
	logic           chan4Stage1Out;
	logic           dutyCorrEn;
	logic [1:0]     divCnt = 2'h0;
	int             fails = 0;
	int             checked = 0;
	int             cyc = 0;
	int             n;
	int             hiLen;
	int             loLen;
	logic [31:0]    rd;
	logic [31:0]    w;
	logic           err;
	logic           lvl;
	lcdiv_cycles_t  cy;
	logic [9:0]     idxTab [6] = '{`LCDIV_IDX_C3S1, `LCDIV_IDX_C3PH, `LCDIV_IDX_C3S2,
		`LCDIV_IDX_C3CTL, `LCDIV_IDX_C3DCC, `LCDIV_IDX_C4S1};
	lcdiv_channel i_lcdiv_channel (.core_clk(core_clk), .rst_n(rst_n), .apbReq(req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .divIn(divIn),
		.syncIn_n(syncIn_n), .chan3Out(chan3Out), .chan4Stage1Out(chan4Stage1Out),
		.dutyCorrEn(dutyCorrEn));
	initial forever #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		divCnt <= divCnt + 2'h1;
		divIn <= divCnt[1];
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails = fails + 1;
			results();
		end
	end
	function automatic logic [31:0] regMask(input logic [9:0] idx);
		return (idx == `LCDIV_IDX_C3CTL) ? 32'h0000_003f :
			(idx == `LCDIV_IDX_C3DCC) ? 32'h0000_0001 : 32'h0000_00ff;
	endfunction : regMask
	function automatic logic [31:0] expLen(input logic [3:0] v);
		return (32'(v) + 32'h0000_0001) * 32'h0000_0004;
	endfunction : expLen
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp32
	task automatic cmpBit(input logic got, input logic exp);
		cmp32({31'h0, got}, {31'h0, exp});
	endtask : cmpBit
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge core_clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= {idx, 2'b00};
		req.pwdata <= wd;
		@(posedge core_clk);
		req.penable <= 1'b1;
		do begin
			@(negedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20)
			fails++;
		rd = prdata;
		err = pslverr;
		@(posedge core_clk);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb
	task automatic run(input logic sel, input logic v, output int len);
		len = 0;
		while ((sel ? chan3Out : chan4Stage1Out) === v && len < 400) begin
			@(posedge core_clk);
			len++;
		end
	endtask : run
	task automatic measure(input logic sel);
		run(sel, 1'b1, n);
		run(sel, 1'b0, n);
		run(sel, 1'b1, hiLen);
		run(sel, 1'b0, loLen);
	endtask : measure
	task results;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	initial begin
		w = $urandom(32'h40d9d416);
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		cmpBit(dutyCorrEn, 1'b1);
		foreach (idxTab[i]) begin
			apb(1'b0, idxTab[i], 32'h0);
			cmp32(rd, 32'h0);
		end
		foreach (idxTab[i]) begin
			w = $urandom;
			apb(1'b1, idxTab[i], w);
			apb(1'b0, idxTab[i], 32'h0);
			cmp32(rd, w & regMask(idxTab[i]));
			cmpBit(err, 1'b0);
		end
		apb(1'b1, 10'h000, 32'hffff_ffff);
		cmpBit(err, 1'b1);
		apb(1'b0, 10'h000, 32'h0);
		cmp32(rd, 32'h0);
		apb(1'b1, `LCDIV_IDX_C3DCC, 32'h1);
		repeat (3) @(posedge core_clk);
		cmpBit(dutyCorrEn, 1'b0);
		apb(1'b1, `LCDIV_IDX_C3CTL, 32'h0000_000c);
		run(1'b1, 1'b0, n);
		cmpBit(chan3Out, 1'b1);
		apb(1'b1, `LCDIV_IDX_C3CTL, 32'h0000_0008);
		run(1'b1, 1'b1, n);
		cmpBit(chan3Out, 1'b0);
		apb(1'b1, `LCDIV_IDX_C3CTL, 32'h0000_0020);
		for (int i = 0; i < 4; i++) begin
			cy = (i == 0) ? '0 : lcdiv_cycles_t'(8'($urandom) & 8'h33);
			apb(1'b1, `LCDIV_IDX_C4S1, 32'(cy));
			apb(1'b1, `LCDIV_IDX_C3S1, 32'(cy));
			measure(1'b0);
			cmp32(hiLen, expLen(cy.high));
			cmp32(loLen, expLen(cy.low));
			measure(1'b1);
			cmp32(hiLen, expLen(cy.high));
			cmp32(loLen, expLen(cy.low));
		end
		apb(1'b1, `LCDIV_IDX_C3S1, 32'h0);
		for (int i = 0; i < 3; i++) begin
			cy = lcdiv_cycles_t'(8'($urandom) & 8'h33);
			apb(1'b1, `LCDIV_IDX_C3S2, 32'(cy));
			apb(1'b1, `LCDIV_IDX_C3CTL, 32'h0000_0000);
			measure(1'b1);
			cmp32(hiLen, 32'h0000_0002 * expLen(cy.high));
			cmp32(loLen, 32'h0000_0002 * expLen(cy.low));
			apb(1'b1, `LCDIV_IDX_C3CTL, 32'h0000_0010);
			measure(1'b1);
			cmp32(hiLen, expLen(cy.high));
			cmp32(loLen, expLen(cy.low));
		end
		apb(1'b1, `LCDIV_IDX_C3CTL, 32'h0000_0020);
		syncIn_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		lvl = chan4Stage1Out;
		run(1'b0, lvl, n);
		cmp32(n, 400);
		syncIn_n <= 1'b1;
		results();
	end
endmodule : test_lcdiv_channel
